//--- bench/cbx_chk.sv
`timescale 1ns/1ns
module cbx_chk (
  // clock and reset
  input wire logic MCLK_I,
  input wire logic RESET_N_I,
  // timing pins of both directions
  input wire logic RX_CBIT_CLOCK_O,
  input wire logic RX_CBIT_FRAME_PULSE_O,
  input wire logic RX_CBIT_MARKER_STROBE_O,
  input wire logic TX_CBIT_CLOCK_O,
  input wire logic TX_CBIT_FRAME_PULSE_O,
  input wire logic TX_CBIT_MARKER_STROBE_O,
  // receive data
  input wire logic RX_CBIT_DATA_OUT_O
);
  wire rc = RX_CBIT_CLOCK_O;
  wire rf = RX_CBIT_FRAME_PULSE_O;
  wire rm = RX_CBIT_MARKER_STROBE_O;
  wire tc = TX_CBIT_CLOCK_O;
  wire tf = TX_CBIT_FRAME_PULSE_O;
  wire tm = TX_CBIT_MARKER_STROBE_O;
  wire rd = RX_CBIT_DATA_OUT_O;
  // a whole C-bit period is too long for a plain delay, so age counters time it;
  // an age is cleared at the event and reads this value one period later
  localparam logic [8:0] AGE_DUE = 9'h17b;
  logic       rc_q        = 1'b0;
  logic       rf_q        = 1'b0;
  logic       tc_q        = 1'b0;
  logic       tf_q        = 1'b0;
  logic [8:0] rx_fp_age_q = 9'h1ff;
  logic [8:0] tx_fp_age_q = 9'h1ff;
  logic [8:0] rx_tl_age_q = 9'h1ff;
  logic [8:0] tx_tl_age_q = 9'h1ff;
  function automatic logic [8:0] age_step(input logic clr, input logic [8:0] age);
    if (clr) return 9'h000;
    return (age == 9'h1ff) ? age : age + 9'h001;
  endfunction
  // marker falls on the edge of the second fall, so only the first fall sees it high
  always @(posedge MCLK_I) begin
    rc_q        <= rc;
    rf_q        <= rf;
    tc_q        <= tc;
    tf_q        <= tf;
    rx_fp_age_q <= age_step(rf && !rf_q, rx_fp_age_q);
    tx_fp_age_q <= age_step(tf && !tf_q, tx_fp_age_q);
    rx_tl_age_q <= age_step(!rc && rc_q && rm, rx_tl_age_q);
    tx_tl_age_q <= age_step(!tc && tc_q && tm, tx_tl_age_q);
  end
  default clocking cb @(posedge MCLK_I); endclocking
  default disable iff (!RESET_N_I);
  sequence s_rx; $rose(rf); endsequence
  sequence s_tx; $rose(tf); endsequence
  sequence s_rx_due; rx_fp_age_q == AGE_DUE; endsequence
  sequence s_tx_due; tx_fp_age_q == AGE_DUE; endsequence
  sequence s_rx_tail; rx_tl_age_q == AGE_DUE; endsequence
  sequence s_tx_tail; tx_tl_age_q == AGE_DUE; endsequence
  a_rx_fp_width: assert property (s_rx |-> ##190 $fell(rf)) else $error("rx fp width");
  a_rx_clk_start: assert property (s_rx_due |-> $rose(rc)) else $error("rx clk start");
  a_rx_mark_lead: assert property ($rose(rm) |-> ##190 $rose(rc)) else $error("rx lead");
  a_rx_mark_tail: assert property (s_rx_tail |-> $fell(rm)) else $error("rx tail");
  a_rx_data_hold: assert property ($rose(rc) |=> $stable(rd)[*4]) else $error("rx early");
  a_tx_fp_width: assert property (s_tx |-> ##190 $fell(tf)) else $error("tx fp width");
  a_tx_clk_start: assert property (s_tx_due |-> $rose(tc)) else $error("tx clk start");
  a_tx_mark_lead: assert property ($rose(tm) |-> ##190 $rose(tc)) else $error("tx lead");
  a_tx_mark_tail: assert property (s_tx_tail |-> $fell(tm)) else $error("tx tail");
endmodule

bind cbx_cbit_port cbx_chk u_chk (
  .MCLK_I(MCLK_I), .RESET_N_I(RESET_N_I), .RX_CBIT_CLOCK_O(RX_CBIT_CLOCK_O),
  .RX_CBIT_FRAME_PULSE_O(RX_CBIT_FRAME_PULSE_O),
  .RX_CBIT_MARKER_STROBE_O(RX_CBIT_MARKER_STROBE_O), .TX_CBIT_CLOCK_O(TX_CBIT_CLOCK_O),
  .TX_CBIT_FRAME_PULSE_O(TX_CBIT_FRAME_PULSE_O),
  .TX_CBIT_MARKER_STROBE_O(TX_CBIT_MARKER_STROBE_O),
  .RX_CBIT_DATA_OUT_O(RX_CBIT_DATA_OUT_O));

//--- bench/cbx_far.sv
`timescale 1ns/1ns
module cbx_far (
  // clock
  input  wire logic                  clk_i,
  // port pins from the block, and the tx word from the bench
  input  wire cbx_pkg::cbx_pins_type rx_i,
  input  wire logic                  rx_data_i,
  input  wire cbx_pkg::cbx_pins_type tx_i,
  input  wire logic [13:0]           word_i,
  // to the block and to the bench
  output logic                       tx_data_o = 1'b0,
  output logic                       smp_o = 1'b0,
  output logic                       bit_o,
  output logic [3:0]                 cnt_o
);
  logic       rc_q = 1'b0;
  logic       tc_q = 1'b0;
  logic       act_q = 1'b0;
  logic [3:0] idx_q = 4'h0;
  always @(posedge clk_i) begin
    rc_q <= rx_i.clock;
    tc_q <= tx_i.clock;
    // data moves just after the rise, so take it at the fall
    smp_o <= rc_q & ~rx_i.clock;
    bit_o <= rx_data_i;
    if (tx_i.frame_pulse) begin
      act_q <= 1'b1;
      idx_q <= 4'h0;
      cnt_o <= 4'h0;
    end else begin
      if (~tc_q & tx_i.clock) cnt_o <= cnt_o + 4'h1;
      // step at the fall, half a period clear of the capture edge
      if (tc_q & ~tx_i.clock) idx_q <= idx_q + 4'h1;
      if (idx_q == 4'he) act_q <= 1'b0;
    end
    // outside a frame the line toggles so stale data cannot pass
    if (!act_q) tx_data_o <= ~tx_data_o;
    else tx_data_o <= (idx_q < 4'he) ? word_i[idx_q] : 1'b1;
  end
endmodule

//--- bench/testbench.sv
`timescale 1ns/1ns
`include "cbx_map.svh"
`define CHK(nm, e, s) begin \
  num_checks++; \
  if ((e) !== (s)) begin \
    errors++; \
    $display("CHECK FAILED %s exp %h got %h", nm, e, s); \
  end \
end
module testbench;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic ds3 = 1'b0;
  logic rxs = 1'b0;
  logic txs = 1'b0;
  logic omit = 1'b0;
  logic [`CBX_RX_BITS-1:0] rxw = '0;
  logic [`CBX_TX_BITS-1:0] txw = '0;
  logic [15:0] r = 16'h001b;
  wire cbx_pkg::cbx_pins_type rxp;
  wire cbx_pkg::cbx_pins_type txp;
  wire rxd, tv, tdi, smp, sb;
  wire [3:0] cnt;
  wire [13:0] tco;
  logic eb;
  logic [17:0] ew;
  logic q_rx[$];
  logic [17:0] q_tx[$];
  int errors = 0;
  int num_checks = 0;
  cbx_cbit_port dut_u (
    .MCLK_I(clk), .RESET_N_I(rst_n), .DS3_CLK_I(ds3),
    .RX_FRAME_START_I(rxs), .RX_CBITS_I(rxw),
    .RX_CBIT_CLOCK_O(rxp.clock), .RX_CBIT_FRAME_PULSE_O(rxp.frame_pulse),
    .RX_CBIT_MARKER_STROBE_O(rxp.marker_strobe), .RX_CBIT_DATA_OUT_O(rxd),
    .TX_FRAME_START_I(txs), .TX_CBIT_DATA_IN_I(tdi),
    .TX_CBIT_CLOCK_O(txp.clock), .TX_CBIT_FRAME_PULSE_O(txp.frame_pulse),
    .TX_CBIT_MARKER_STROBE_O(txp.marker_strobe), .TX_CBITS_O(tco),
    .TX_CBITS_VALID_O(tv), .FEAC_PULSE_OMIT_I(omit));
  cbx_far far_u (.clk_i(clk), .rx_i(rxp), .rx_data_i(rxd), .tx_i(txp),
    .word_i(txw), .tx_data_o(tdi), .smp_o(smp), .bit_o(sb), .cnt_o(cnt));
  always #5 clk = ~clk;
  // line clock free-running, phase unrelated to clk
  always begin
    #62 ds3 = 1'b1;
    #63 ds3 = 1'b0;
  end
  function automatic logic [15:0] lfsr(input logic [15:0] v);
    return {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
  endfunction
  task report_and_stop;
    $display("checks %0d errors %0d", num_checks, errors);
    if (errors == 0 && num_checks > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  // one rx and one tx sequence; rfs adds a start that must be ignored
  task automatic run(input logic o, input logic rfs);
    @(negedge clk);
    r = lfsr(r);
    rxw = r[13:0];
    r = lfsr(r);
    txw = r[13:0];
    omit = o;
    for (int i = 0; i < 14; i++) q_rx.push_back(rxw[i]);
    q_tx.push_back(o ? {4'hd, 1'b1, txw[12:0]} : {4'he, txw});
    rxs = 1'b1;
    txs = 1'b1;
    @(negedge clk);
    rxs = 1'b0;
    txs = 1'b0;
    // mode flips right after start: it must have been latched
    omit = ~o;
    if (rfs) begin
      repeat (1000) @(negedge clk);
      rxw = ~rxw;
      rxs = 1'b1;
      txs = 1'b1;
      @(negedge clk);
      rxs = 1'b0;
      txs = 1'b0;
    end
    // next start lands on the first edge allowed after the rx sequence
    repeat (rfs ? 4698 : 5699) @(negedge clk);
    $display("test omit=%0d refuse=%0d done", o, rfs);
  endtask
  always @(posedge clk) begin
    if (smp === 1'b1) begin
      eb = q_rx.pop_front();
      `CHK("rx bit", eb, sb)
    end
    if (tv === 1'b1) begin
      ew = q_tx.pop_front();
      `CHK("tx word", ew, {cnt, tco})
    end
  end
  initial begin
    repeat (4) @(negedge clk);
    `CHK("reset rx data", 1'b1, rxd)
    `CHK("reset tx word", 14'h3fff, tco)
    rst_n = 1'b1;
    repeat (3) @(negedge clk);
    run(1'b0, 1'b0);
    run(1'b1, 1'b1);
    run(1'b0, 1'b1);
    run(1'b1, 1'b0);
    repeat (800) @(negedge clk);
    `CHK("left over", 0, q_rx.size() + q_tx.size())
    report_and_stop;
  end
  initial begin
    #300000;
    errors++;
    report_and_stop;
  end
endmodule

//--- design/cbx_cbit_port.sv
// Behaviour
// - rx C-bit clock 3800 ns, first rise 3800 after frame
// - rx frame pulse high 1900 ns per sequence
// - rx data changes half to one and a half DS3 clocks after rise
// - rx marker rises 1900 ns before clock rise
// - rx marker falls 3800 ns after clock fall
// - tx frame pulse 1900 ns, clock 3800 after
// - tx marker rises 1900 ns before clock rise
// - tx marker falls 3800 ns after clock fall
// - tx data captured on tx clock rise
// - feac pulse present while omit control is 0
// - omit control 1 drops the tx feac pulse; rx keeps all 14 bits
`timescale 1ns/1ns
`include "cbx_map.svh"

module cbx_seq (
  // clock and reset
  input  wire logic                   clk_i,
  input  wire logic                   rst_n_i,
  // control
  input  wire logic                   start_i,
  input  wire logic [`CBX_SLOT_W-1:0] nbits_i,
  // pins and events
  output cbx_pkg::cbx_pins_type       pins_o,
  output logic                        rise_o,
  output logic [`CBX_SLOT_W-1:0]      slot_o,
  output logic                        done_o
);

  logic                   busy_q;
  logic [`CBX_SLOT_W-1:0] slot_q;
  logic [`CBX_CNT_W-1:0]  cnt_q;
  cbx_pkg::cbx_pins_type  pins_q;
  cbx_pkg::cbx_pins_type  pins_d;
  logic                   rise_q;
  logic [`CBX_SLOT_W-1:0] rslot_q;
  logic                   done_q;

  wire wrap      = cnt_q == `CBX_CNT_W'(`CBX_CYC_CLKS - 1);
  wire last      = slot_q == nbits_i;
  wire first_hlf = cnt_q < `CBX_CNT_W'(`CBX_HALF_CLKS);
  wire in_frame  = slot_q == `CBX_SLOT_W'(0);
  wire rise_d    = busy_q && !in_frame && cnt_q == `CBX_CNT_W'(0);

  // a start during a running sequence is ignored so no pulse is ever cut short
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      busy_q <= 1'b0;
      slot_q <= `CBX_SLOT_W'(0);
      cnt_q  <= `CBX_CNT_W'(0);
    end else if (start_i && !busy_q) begin
      busy_q <= 1'b1;
      slot_q <= `CBX_SLOT_W'(0);
      cnt_q  <= `CBX_CNT_W'(0);
    end else if (busy_q && wrap) begin
      cnt_q  <= `CBX_CNT_W'(0);
      busy_q <= !last;
      slot_q <= last ? slot_q : slot_q + `CBX_SLOT_W'(1);
    end else if (busy_q) begin
      cnt_q <= cnt_q + `CBX_CNT_W'(1);
    end
  end

  always_comb begin
    pins_d.frame_pulse   = busy_q && in_frame && first_hlf;
    pins_d.clock         = busy_q && !in_frame && first_hlf;
    pins_d.marker_strobe = busy_q && ((in_frame && !first_hlf)
                           || slot_q == `CBX_SLOT_W'(1)
                           || (slot_q == `CBX_SLOT_W'(`CBX_MARK_END_SLOT)
                               && first_hlf));
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      pins_q  <= '0;
      rise_q  <= 1'b0;
      rslot_q <= `CBX_SLOT_W'(0);
      done_q  <= 1'b0;
    end else begin
      pins_q  <= pins_d;
      rise_q  <= rise_d;
      rslot_q <= slot_q;
      done_q  <= busy_q && wrap && last;
    end
  end

  assign pins_o = pins_q;
  assign rise_o = rise_q;
  assign slot_o = rslot_q;
  assign done_o = done_q;

endmodule

module cbx_cbit_port (
  // clock and reset
  input  wire logic                   MCLK_I,
  input  wire logic                   RESET_N_I,
  // active DS3 clock, receive or transmit, from outside
  input  wire logic                   DS3_CLK_I,
  // receive C-bits from the framer
  input  wire logic                   RX_FRAME_START_I,
  input  wire logic [`CBX_RX_BITS-1:0] RX_CBITS_I,
  // receive external port
  output logic                        RX_CBIT_CLOCK_O,
  output logic                        RX_CBIT_FRAME_PULSE_O,
  output logic                        RX_CBIT_MARKER_STROBE_O,
  output logic                        RX_CBIT_DATA_OUT_O,
  // transmit external port
  input  wire logic                   TX_FRAME_START_I,
  input  wire logic                   TX_CBIT_DATA_IN_I,
  output logic                        TX_CBIT_CLOCK_O,
  output logic                        TX_CBIT_FRAME_PULSE_O,
  output logic                        TX_CBIT_MARKER_STROBE_O,
  // transmit C-bits to the framer
  output logic [`CBX_TX_BITS-1:0]     TX_CBITS_O,
  output logic                        TX_CBITS_VALID_O,
  // configuration
  input  wire logic                   FEAC_PULSE_OMIT_I
);

  function automatic logic [`CBX_SLOT_W-1:0] bit_idx(input logic [`CBX_SLOT_W-1:0] slot);
    bit_idx = slot - `CBX_SLOT_W'(1);
  endfunction

  logic                    rst_s1_q;
  logic                    rst_n;
  logic                    ds3_s1_q;
  logic                    ds3_s2_q;
  logic                    ds3_s3_q;
  logic                    cdt_s1_q;
  logic                    cdt_s2_q;
  logic [`CBX_RX_BITS-1:0] rx_bits_q;
  logic                    rx_next_q;
  logic                    rx_pend_q;
  logic                    rx_data_q;
  logic [`CBX_SLOT_W-1:0]  tx_nbits_q;
  logic [`CBX_TX_BITS-1:0] tx_shift_q;
  logic [`CBX_TX_BITS-1:0] tx_out_q;
  logic                    tx_valid_q;
  logic                    rx_armed_q;
  logic                    rx_run_q;
  logic                    tx_run_q;

  cbx_pkg::cbx_pins_type   rx_pins;
  cbx_pkg::cbx_pins_type   tx_pins;
  logic                    rx_rise;
  logic [`CBX_SLOT_W-1:0]  rx_slot;
  logic                    tx_rise;
  logic [`CBX_SLOT_W-1:0]  tx_slot;
  logic                    tx_done;
  logic                    rx_done;

  always_ff @(posedge MCLK_I or negedge RESET_N_I) begin
    if (!RESET_N_I) begin
      rst_s1_q <= 1'b0;
      rst_n    <= 1'b0;
    end else begin
      rst_s1_q <= 1'b1;
      rst_n    <= rst_s1_q;
    end
  end

  // the third stage only feeds the edge detector, never the first
  always_ff @(posedge MCLK_I or negedge rst_n) begin
    if (!rst_n) begin
      ds3_s1_q <= 1'b0;
      ds3_s2_q <= 1'b0;
      ds3_s3_q <= 1'b0;
      cdt_s1_q <= 1'b1;
      cdt_s2_q <= 1'b1;
    end else begin
      ds3_s1_q <= DS3_CLK_I;
      ds3_s2_q <= ds3_s1_q;
      ds3_s3_q <= ds3_s2_q;
      cdt_s1_q <= TX_CBIT_DATA_IN_I;
      cdt_s2_q <= cdt_s1_q;
    end
  end

  wire ds3_rise = ds3_s2_q && !ds3_s3_q;
  wire ds3_fall = !ds3_s2_q && ds3_s3_q;
  // a start counts only where the sequencer takes it, so a refused one touches no state
  wire rx_start = RX_FRAME_START_I && (!rx_run_q || rx_done);
  wire tx_start = TX_FRAME_START_I && (!tx_run_q || tx_done);
  wire [`CBX_SLOT_W-1:0] tx_nbits_d = FEAC_PULSE_OMIT_I ?
                                      `CBX_SLOT_W'(`CBX_TX_BITS_SHORT) :
                                      `CBX_SLOT_W'(`CBX_TX_BITS);

  cbx_seq u_rx_seq (
    .clk_i   (MCLK_I),
    .rst_n_i (rst_n),
    .start_i (rx_start),
    .nbits_i (`CBX_SLOT_W'(`CBX_RX_BITS)),
    .pins_o  (rx_pins),
    .rise_o  (rx_rise),
    .slot_o  (rx_slot),
    .done_o  (rx_done)
  );

  cbx_seq u_tx_seq (
    .clk_i   (MCLK_I),
    .rst_n_i (rst_n),
    .start_i (tx_start),
    .nbits_i (tx_nbits_q),
    .pins_o  (tx_pins),
    .rise_o  (tx_rise),
    .slot_o  (tx_slot),
    .done_o  (tx_done)
  );

  // mirrors the sequencer's busy span; a start and the end in one cycle keep it set
  always_ff @(posedge MCLK_I or negedge rst_n) begin
    if (!rst_n) begin
      rx_run_q <= 1'b0;
      tx_run_q <= 1'b0;
    end else begin
      rx_run_q <= rx_start || (rx_run_q && !rx_done);
      tx_run_q <= tx_start || (tx_run_q && !tx_done);
    end
  end

  // receive: waiting for a DS3 fall before the DS3 rise keeps the data
  // change between half and one and a half DS3 cycles after the clock rise
  always_ff @(posedge MCLK_I or negedge rst_n) begin
    if (!rst_n) begin
      rx_bits_q  <= '1;
      rx_next_q  <= `CBX_DATA_RST;
      rx_pend_q  <= 1'b0;
      rx_armed_q <= 1'b0;
      rx_data_q  <= `CBX_DATA_RST;
    end else begin
      if (rx_start) begin
        rx_bits_q <= RX_CBITS_I;
      end
      if (rx_rise) begin
        rx_next_q  <= rx_bits_q[bit_idx(rx_slot)];
        rx_pend_q  <= 1'b1;
        rx_armed_q <= 1'b0;
      end else if (rx_pend_q && ds3_fall) begin
        rx_armed_q <= 1'b1;
      end else if (rx_pend_q && rx_armed_q && ds3_rise) begin
        rx_data_q <= rx_next_q;
        rx_pend_q <= 1'b0;
      end
    end
  end

  // transmit: length latched per sequence so a mid-frame change cannot cut it
  always_ff @(posedge MCLK_I or negedge rst_n) begin
    if (!rst_n) begin
      tx_nbits_q <= `CBX_SLOT_W'(`CBX_TX_BITS);
      tx_shift_q <= '1;
      tx_out_q   <= '1;
      tx_valid_q <= 1'b0;
    end else begin
      tx_valid_q <= tx_done;
      if (tx_start) begin
        tx_nbits_q <= tx_nbits_d;
        tx_shift_q <= '1;
      end else if (tx_rise) begin
        tx_shift_q[bit_idx(tx_slot)] <= cdt_s2_q;
      end
      if (tx_done) begin
        tx_out_q <= tx_shift_q;
      end
    end
  end

  assign RX_CBIT_CLOCK_O         = rx_pins.clock;
  assign RX_CBIT_FRAME_PULSE_O   = rx_pins.frame_pulse;
  assign RX_CBIT_MARKER_STROBE_O = rx_pins.marker_strobe;
  assign RX_CBIT_DATA_OUT_O      = rx_data_q;
  assign TX_CBIT_CLOCK_O         = tx_pins.clock;
  assign TX_CBIT_FRAME_PULSE_O   = tx_pins.frame_pulse;
  assign TX_CBIT_MARKER_STROBE_O = tx_pins.marker_strobe;
  assign TX_CBITS_O              = tx_out_q;
  assign TX_CBITS_VALID_O        = tx_valid_q;

endmodule

//--- design/cbx_map.svh
`ifndef CBX_MAP_SVH
`define CBX_MAP_SVH

// timing base
`define CBX_MCLK_MHZ      100
`define CBX_CYC_NS        3800
`define CBX_HALF_NS       1900
`define CBX_CYC_CLKS      ((`CBX_CYC_NS * `CBX_MCLK_MHZ) / 1000)
`define CBX_HALF_CLKS     ((`CBX_HALF_NS * `CBX_MCLK_MHZ) / 1000)

// counter widths
`define CBX_CNT_W         9
`define CBX_SLOT_W        4

// sequence lengths
`define CBX_RX_BITS       14
`define CBX_TX_BITS       14
`define CBX_TX_BITS_SHORT 13

// marker strobe spans frame slot tail, slot 1, and head of this slot
`define CBX_MARK_END_SLOT 2

// reset levels
`define CBX_DATA_RST      1'b1

`endif

//--- design/cbx_pkg.sv
package cbx_pkg;

  // the three timing pins of one direction
  typedef struct packed {
    logic clock;
    logic frame_pulse;
    logic marker_strobe;
  } cbx_pins_type;

endpackage
